// ==== hw/ext_bus_pin_control.sv ====
// External-bus pin control: reset and grant pin states, write byte
// enables, internal address multiplexing and the reset-pin initiator.
// Assumes all inputs but the two resets, i_arst_n and i_por_n, are synchronous to i_core_clk.
`include "ext_bus_pin_params.svh"

// Summary of operation
// - Reset: float address, mux/request low, CAS high.
// - Reset: float selects and data, DMA acks high.
// - Reset: master ack, DRAM strobes held high.
// - Reset: error/grant low, OE floats, reset pin floats.
// - Reset: read/write floats, transfer controls become inputs.
// - Reset: bus state low, enables float, transmit high.
// - Grant: address inputs, data floats, master drives.
// - Grant: chip selects float, row strobes keep working.
// - Grant: OE, top control, R/W inputs; rest high.
// - Grant: byte enables carry master address bits.
// - Grant: DMA acks high, grant asserted, others operate.
// - 8-bit: address on upper enables, first strobes.
// - 16-bit: high/low byte enables, address on upper.
// - 32-bit: one enable per byte lane.
// - Row cycle: a6-a13 on A11-A18, a12-a22 above.
// - Column cycle: a6-a12, a21-a31; A11 unused.
// - Reset initiator: 2048 low, release three after low.
// - DRAM transfer: first two enables held high.
module ext_bus_pin_control #(
  parameter int RST_DRIVE_CYCLES = `RST_DRIVE_MIN_CYC
) (
  // Clock and resets.
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_por_n,
  // Bus interface unit side.
  input wire ext_bus_pin_pkg::core_pins_t i_core,
  input wire ext_bus_pin_pkg::xfer_t i_xfer,
  input wire logic i_hold_grant,
  input wire logic [3:0] i_row_strobe_mode,
  input wire logic i_sys_reset_req,
  output ext_bus_pin_pkg::ext_req_t o_ext_req,
  output logic o_sys_reset_busy,
  // Address and data pins.
  input wire logic [6:29] i_addr_pin,
  output logic [6:29] o_addr_pin,
  output logic o_addr_oe,
  input wire logic [31:0] i_data_pin,
  output logic [31:0] o_data_pin,
  output logic o_data_oe,
  output logic [31:0] o_ext_data,
  // Strobes and selects.
  output logic o_addr_mux_phase,
  output logic o_bus_request_out,
  output logic [3:0] o_cas_n,
  output logic [3:0] o_chip_select_low_n,
  output logic o_chip_select_low_oe,
  output logic [3:0] o_shared_select_row_strobe_n,
  output logic [3:0] o_shared_select_row_strobe_oe,
  output logic [3:0] o_dma_acknowledge_n,
  output logic o_ext_master_ack_n,
  output logic o_dram_output_enable_n,
  output logic o_dram_write_enable_n,
  output logic o_error,
  output logic o_bus_grant_out,
  // Two-way control pins.
  input wire logic i_oe_pin_n,
  output logic o_oe_pin_n,
  output logic o_oe_pin_oe,
  input wire logic i_reset_pin_n,
  output logic o_reset_pin_n,
  output logic o_reset_pin_oe,
  input wire logic i_rw_pin,
  output logic o_rw_pin,
  output logic o_rw_oe,
  output logic [2:0] o_transfer_ctrl_low_n,
  output logic o_transfer_ctrl_low_oe,
  input wire logic i_transfer_ctrl_top_n,
  output logic o_transfer_ctrl_top_n,
  output logic o_transfer_ctrl_top_oe,
  input wire logic [0:3] i_write_byte_enable,
  output logic [0:3] o_write_byte_enable,
  output logic o_write_byte_enable_oe,
  // Status pins.
  output logic [6:0] o_bus_state_out,
  output logic o_serial_transmit_out
);

  logic normal;
  logic [0:3] wbe_nxt;
  logic [6:29] addr_nxt;
  ext_bus_pin_pkg::rst_state_t rst_st_r;
  logic [11:0] rst_cnt_r;

  assign normal = !i_hold_grant;

  // Write byte enables; idle lanes stay high outside a write strobe.
  always_comb begin
    logic we;
    we = i_xfer.wr_strobe;
    wbe_nxt = 4'hf;
    unique case (i_xfer.width)
      ext_bus_pin_pkg::BW_8: begin
        wbe_nxt = {!we, 1'b1, i_xfer.addr[30:31]};
      end
      ext_bus_pin_pkg::BW_16: begin
        wbe_nxt[2:3] = i_xfer.addr[30:31];
        if (i_xfer.size == ext_bus_pin_pkg::SZ_BYTE) begin
          wbe_nxt[0] = !(we && !i_xfer.addr[31]);
          wbe_nxt[1] = !(we && i_xfer.addr[31]);
        end else begin
          wbe_nxt[0:1] = {2{!we}};
        end
      end
      default: begin
        for (int i = 0; i < 4; i++) begin
          unique case (i_xfer.size)
            ext_bus_pin_pkg::SZ_WORD: wbe_nxt[i] = !we;
            ext_bus_pin_pkg::SZ_HALF:
              wbe_nxt[i] = !(we && (i[1] == i_xfer.addr[30]));
            default:
              wbe_nxt[i] = !(we && (i[1:0] == i_xfer.addr[30:31]));
          endcase
        end
      end
    endcase
    if (i_xfer.dram) begin
      wbe_nxt[0:1] = 2'b11;
    end
  end

  // Address pins, either straight or multiplexed for DRAM rows and columns.
  always_comb begin
    addr_nxt = i_xfer.addr[6:29];
    if (i_xfer.int_mux && !i_xfer.col_phase) begin
      for (int i = 0; i < `ROW_GRP0_LEN; i++) begin
        addr_nxt[`MUX_GRP0_PIN + i] = i_xfer.addr[`ROW_GRP0_BIT + i];
      end
      for (int i = 0; i < `GRP1_LEN; i++) begin
        addr_nxt[`MUX_GRP1_PIN + i] = i_xfer.addr[`ROW_GRP1_BIT + i];
      end
    end else if (i_xfer.int_mux) begin
      // The unused column pin is held low rather than left to wander.
      addr_nxt[`MUX_GRP0_PIN] = 1'b0;
      for (int i = 0; i < `COL_GRP0_LEN; i++) begin
        addr_nxt[`MUX_GRP0_PIN + 1 + i] = i_xfer.addr[`COL_GRP0_BIT + i];
      end
      for (int i = 0; i < `GRP1_LEN; i++) begin
        addr_nxt[`MUX_GRP1_PIN + i] = i_xfer.addr[`COL_GRP1_BIT + i];
      end
    end
  end

  // Address and data pins.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_addr_pin <= '0;
      o_addr_oe <= 1'b0;
      o_data_pin <= 32'h0;
      o_data_oe <= 1'b0;
      o_addr_mux_phase <= 1'b0;
    end else begin
      o_addr_pin <= addr_nxt;
      o_addr_oe <= normal;
      o_data_pin <= i_core.data;
      o_data_oe <= normal && i_core.data_drive;
      o_addr_mux_phase <= i_xfer.int_mux && i_xfer.col_phase;
    end
  end

  // Selects, strobes and acknowledges.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bus_request_out <= 1'b0;
      o_cas_n <= 4'hf;
      o_chip_select_low_n <= 4'hf;
      o_chip_select_low_oe <= 1'b0;
      o_shared_select_row_strobe_n <= 4'hf;
      o_shared_select_row_strobe_oe <= 4'h0;
      o_dma_acknowledge_n <= 4'hf;
      o_ext_master_ack_n <= 1'b1;
      o_dram_output_enable_n <= 1'b1;
      o_dram_write_enable_n <= 1'b1;
      o_error <= 1'b0;
      o_bus_grant_out <= 1'b0;
    end else begin
      o_bus_request_out <= i_core.bus_req;
      o_cas_n <= i_core.cas_n;
      o_chip_select_low_n <= i_core.cs_low_n;
      o_chip_select_low_oe <= normal;
      for (int i = 0; i < 4; i++) begin
        o_shared_select_row_strobe_n[i] <= i_row_strobe_mode[i] ?
            i_core.ras_n[i] : i_core.cs_high_n[i];
        // Row strobes stay driven so refresh runs on during a grant.
        o_shared_select_row_strobe_oe[i] <= i_row_strobe_mode[i] || normal;
      end
      o_dma_acknowledge_n <= normal ? i_core.dma_ack_n : 4'hf;
      o_ext_master_ack_n <= i_core.ext_master_ack_n;
      o_dram_output_enable_n <= i_core.dram_oe_n;
      o_dram_write_enable_n <= i_core.dram_we_n;
      o_error <= i_core.error;
      o_bus_grant_out <= i_hold_grant;
    end
  end

  // Control pins, all but the low transfer controls turning round to inputs during a grant, and status pins.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_oe_pin_n <= 1'b1;
      o_oe_pin_oe <= 1'b0;
      o_rw_pin <= 1'b1;
      o_rw_oe <= 1'b0;
      o_transfer_ctrl_low_n <= 3'h7;
      o_transfer_ctrl_low_oe <= 1'b0;
      o_transfer_ctrl_top_n <= 1'b1;
      o_transfer_ctrl_top_oe <= 1'b0;
      o_write_byte_enable <= 4'hf;
      o_write_byte_enable_oe <= 1'b0;
      o_bus_state_out <= 7'h0;
      o_serial_transmit_out <= 1'b1;
    end else begin
      o_oe_pin_n <= i_core.oe_n;
      o_oe_pin_oe <= normal;
      o_rw_pin <= i_core.rw;
      o_rw_oe <= normal;
      o_transfer_ctrl_low_n <= normal ? i_core.tc_low_n : 3'h7;
      o_transfer_ctrl_low_oe <= 1'b1;
      o_transfer_ctrl_top_n <= i_core.tc_top_n;
      o_transfer_ctrl_top_oe <= normal;
      o_write_byte_enable <= wbe_nxt;
      o_write_byte_enable_oe <= normal;
      o_bus_state_out <= i_core.bus_state;
      o_serial_transmit_out <= i_core.xmit;
    end
  end

  // External master request, sampled only while the pins are inputs.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ext_req <= '0;
      o_ext_data <= 32'h0;
    end else if (o_bus_grant_out) begin
      o_ext_req.addr[4:5] <= i_write_byte_enable[0:1];
      o_ext_req.addr[6:29] <= i_addr_pin;
      o_ext_req.addr[30:31] <= i_write_byte_enable[2:3];
      o_ext_req.size <= {i_oe_pin_n, i_transfer_ctrl_top_n};
      o_ext_req.rw <= i_rw_pin;
      o_ext_data <= i_data_pin;
    end
  end

  // Reset-pin initiator. It runs on the power-on reset so that the system
  // reset it causes does not cut its own pulse short.
  always_ff @(posedge i_core_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      rst_st_r <= ext_bus_pin_pkg::RS_IDLE;
      rst_cnt_r <= 12'h0;
      o_reset_pin_n <= 1'b1;
      o_reset_pin_oe <= 1'b0;
      o_sys_reset_busy <= 1'b0;
    end else begin
      o_reset_pin_n <= 1'b0;
      unique case (rst_st_r)
        ext_bus_pin_pkg::RS_IDLE: begin
          if (i_sys_reset_req) begin
            rst_st_r <= ext_bus_pin_pkg::RS_DRIVE;
            rst_cnt_r <= 12'h0;
            o_reset_pin_oe <= 1'b1;
            o_sys_reset_busy <= 1'b1;
          end
        end
        ext_bus_pin_pkg::RS_DRIVE: begin
          rst_cnt_r <= rst_cnt_r + 12'h1;
          if (rst_cnt_r == 12'(RST_DRIVE_CYCLES - 2)) begin
            rst_st_r <= ext_bus_pin_pkg::RS_SAMPLE;
          end
        end
        ext_bus_pin_pkg::RS_SAMPLE: begin
          rst_cnt_r <= 12'h0;
          if (!i_reset_pin_n) begin
            rst_st_r <= ext_bus_pin_pkg::RS_RELEASE;
          end
        end
        ext_bus_pin_pkg::RS_RELEASE: begin
          rst_cnt_r <= rst_cnt_r + 12'h1;
          if (rst_cnt_r == 12'(`RST_RELEASE_CYC - 1)) begin
            rst_st_r <= ext_bus_pin_pkg::RS_IDLE;
            o_reset_pin_oe <= 1'b0;
            o_sys_reset_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  property p_reset_float;
    @(posedge i_core_clk) disable iff (!i_por_n)
    !i_arst_n |-> !o_addr_oe && !o_data_oe && !o_write_byte_enable_oe &&
        o_cas_n == 4'hf && o_dma_acknowledge_n == 4'hf && !o_rw_oe;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("Pins not in reset state during reset.");

  property p_grant_turn;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_hold_grant ##1 i_hold_grant |-> !o_addr_oe && !o_data_oe &&
        !o_oe_pin_oe && !o_transfer_ctrl_top_oe && !o_rw_oe &&
        o_transfer_ctrl_low_n == 3'h7 && o_bus_grant_out;
  endproperty
  a_grant_turn: assert property (p_grant_turn)
    else $error("Pins not turned round during grant.");

  property p_grant_dma;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(o_bus_grant_out) |-> o_dma_acknowledge_n == 4'hf &&
        !o_chip_select_low_oe && !o_write_byte_enable_oe;
  endproperty
  a_grant_dma: assert property (p_grant_dma)
    else $error("Acknowledges or selects active during grant.");

  property p_dram_wbe;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_xfer.dram && !i_hold_grant |=> o_write_byte_enable[0:1] == 2'b11;
  endproperty
  a_dram_wbe: assert property (p_dram_wbe)
    else $error("Byte enables low during a DRAM transfer.");

  property p_word_write;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_xfer.width == ext_bus_pin_pkg::BW_32 && !i_xfer.dram &&
        i_xfer.size == ext_bus_pin_pkg::SZ_WORD && i_xfer.wr_strobe
        |=> o_write_byte_enable == 4'h0;
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("Word write does not enable all lanes.");

  property p_narrow_addr;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_xfer.width != ext_bus_pin_pkg::BW_32 ##1 1'b1 |->
        o_write_byte_enable[2:3] == $past(i_xfer.addr[30:31]);
  endproperty
  a_narrow_addr: assert property (p_narrow_addr)
    else $error("Upper byte enables do not carry the low address.");

  property p_col_phase;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_addr_mux_phase |-> o_addr_pin[12] == $past(i_xfer.addr[6]) &&
        o_addr_pin[29] == $past(i_xfer.addr[31]);
  endproperty
  a_col_phase: assert property (p_col_phase)
    else $error("Mux phase high without column address.");

  property p_rst_hold;
    @(posedge i_core_clk) disable iff (!i_por_n)
    $rose(o_reset_pin_oe) |-> (o_reset_pin_oe && !o_reset_pin_n)[*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("Reset pin released too early.");

  property p_rst_release;
    @(posedge i_core_clk) disable iff (!i_por_n)
    rst_st_r == ext_bus_pin_pkg::RS_SAMPLE && !i_reset_pin_n |->
        ##1 o_reset_pin_oe[*3] ##1 !o_reset_pin_oe;
  endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("Reset pin not released three cycles after low.");

endmodule : ext_bus_pin_control

// ==== hw/ext_bus_pin_params.svh ====
// Constants for the external-bus pin control block.
// Assumes it is included by bare name from the design.
`ifndef EXT_BUS_PIN_PARAMS_SVH
`define EXT_BUS_PIN_PARAMS_SVH

// Least number of cycles the reset pin is driven low before sampling.
`define RST_DRIVE_MIN_CYC 2048
// Cycles from sampling the reset pin low to releasing it.
`define RST_RELEASE_CYC 3
// Cycles the system keeps reset low after the release.
`define RST_SYS_HOLD_CYC 5
// First pins of the two multiplexed address groups.
`define MUX_GRP0_PIN 11
`define MUX_GRP1_PIN 19
// Internal address bits shown in the row cycle.
`define ROW_GRP0_BIT 6
`define ROW_GRP1_BIT 12
// Internal address bits shown in the column cycle.
`define COL_GRP0_BIT 6
`define COL_GRP1_BIT 21
// Pins per group in each cycle.
`define ROW_GRP0_LEN 8
`define COL_GRP0_LEN 7
`define GRP1_LEN 11

`endif

// ==== hw/ext_bus_pin_pkg.sv ====
// Types shared by the external-bus pin control block.
// Assumes the constants header sits beside it.
package ext_bus_pin_pkg;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } xfer_size_t;

  typedef enum logic [1:0] {
    BW_8 = 2'b00,
    BW_16 = 2'b01,
    BW_32 = 2'b10
  } bus_width_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_DRIVE = 2'b01,
    RS_SAMPLE = 2'b10,
    RS_RELEASE = 2'b11
  } rst_state_t;

  // Pin values the bus interface unit wants in normal operation.
  typedef struct packed {
    logic bus_req;
    logic [3:0] cas_n;
    logic [3:0] cs_low_n;
    logic [3:0] cs_high_n;
    logic [3:0] ras_n;
    logic [31:0] data;
    logic data_drive;
    logic [3:0] dma_ack_n;
    logic ext_master_ack_n;
    logic dram_oe_n;
    logic dram_we_n;
    logic error;
    logic oe_n;
    logic rw;
    logic [2:0] tc_low_n;
    logic tc_top_n;
    logic [6:0] bus_state;
    logic xmit;
  } core_pins_t;

  // Current transfer as seen by the pin logic.
  typedef struct packed {
    logic [0:31] addr;
    xfer_size_t size;
    bus_width_t width;
    logic dram;
    logic wr_strobe;
    logic int_mux;
    logic col_phase;
  } xfer_t;

  // Request captured from an external master while the bus is granted.
  typedef struct packed {
    logic [4:31] addr;
    logic [1:0] size;
    logic rw;
  } ext_req_t;

endpackage : ext_bus_pin_pkg

// ==== test/ext_bus_far_side.sv ====
// Far side of the pins: an external master during grant, the system
// reset holder and the idle levels of released lines.
// Assumes it sees the grant, the pins that turn round and the reset pin of the device.
module ext_bus_far_side (
  // Clock and master stimulus.
  input wire logic i_clk,
  input wire logic i_en,
  input wire ext_bus_pin_pkg::ext_req_t i_req,
  input wire logic [31:0] i_dat,
  // Device pins.
  input wire logic i_grant,
  input wire logic [6:29] i_a,
  input wire logic i_a_oe,
  input wire logic [31:0] i_d,
  input wire logic i_d_oe,
  input wire logic i_oe,
  input wire logic i_oe_oe,
  input wire logic i_rw,
  input wire logic i_rw_oe,
  input wire logic i_tc3,
  input wire logic i_tc3_oe,
  input wire logic [0:3] i_wbe,
  input wire logic i_wbe_oe,
  input wire logic i_rst,
  input wire logic i_rst_oe,
  // Resolved wire levels.
  output logic [6:29] o_a,
  output logic [31:0] o_d,
  output logic o_oe_n,
  output logic o_rw,
  output logic o_tc3_n,
  output logic [0:3] o_wbe,
  output logic o_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_r = 1'b0;
  logic [31:0] pat_r = 32'h5a3c_96e1;
  logic [2:0] hold_r = 3'h0;

  // Released lines show a changing pattern so a stale value cannot pass.
  always_ff @(negedge i_clk) begin
    drv_r <= i_grant & i_en;
    pat_r <= pat_r * 32'h0001_0dcd + 32'h3c6e_f35f;
  end

  // The system keeps the reset line low five cycles past the release.
  // It lets go on a falling edge, so the device never sees reset end in
  // the same time step as a rising edge it has already acted on.
  always_ff @(negedge i_clk) begin
    if (i_rst_oe) hold_r <= 3'h6;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
  end

  assign o_a = i_a_oe ? i_a : drv_r ? i_req.addr[6:29] : pat_r[23:0];
  assign o_d = i_d_oe ? i_d : drv_r ? i_dat : ~pat_r;
  assign o_oe_n = i_oe_oe ? i_oe : drv_r ? i_req.size[1] : pat_r[0];
  assign o_rw = i_rw_oe ? i_rw : drv_r ? i_req.rw : pat_r[1];
  assign o_tc3_n = i_tc3_oe ? i_tc3 : drv_r ? i_req.size[0] : pat_r[2];
  assign o_wbe = i_wbe_oe ? i_wbe :
      drv_r ? {i_req.addr[4:5], i_req.addr[30:31]} : pat_r[7:4];
  assign o_rst_n = i_rst_oe ? i_rst : (hold_r == 3'h0);
endmodule : ext_bus_far_side

// ==== test/ext_bus_pin_control_test.sv ====
// Self-checking bench for the external-bus pin control block.
// Assumes the package, the design and the far-side model come first.
module ext_bus_pin_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DRV = 16;
  logic i_core_clk, i_por_n, i_hold_grant, i_sys_reset_req, rst_b_n;
  logic i_arst_n, m_en;
  logic [3:0] i_row_strobe_mode;
  ext_bus_pin_pkg::core_pins_t i_core;
  ext_bus_pin_pkg::xfer_t i_xfer;
  ext_bus_pin_pkg::ext_req_t o_ext_req, m_req;
  logic [31:0] m_dat, i_data_pin, o_data_pin, o_ext_data;
  logic [31:0] s = 32'h0001_3e8b;
  logic [6:29] i_addr_pin, o_addr_pin;
  logic [0:3] i_write_byte_enable, o_write_byte_enable;
  logic [3:0] o_cas_n, o_chip_select_low_n, o_shared_select_row_strobe_n;
  logic [3:0] o_shared_select_row_strobe_oe, o_dma_acknowledge_n;
  logic [2:0] o_transfer_ctrl_low_n;
  logic [6:0] o_bus_state_out;
  logic o_sys_reset_busy, o_addr_oe, o_data_oe, o_addr_mux_phase;
  logic o_bus_request_out, o_chip_select_low_oe, o_ext_master_ack_n;
  logic o_dram_output_enable_n, o_dram_write_enable_n, o_error;
  logic o_bus_grant_out, i_oe_pin_n, o_oe_pin_n, o_oe_pin_oe;
  logic i_reset_pin_n, o_reset_pin_n, o_reset_pin_oe, i_rw_pin, o_rw_pin;
  logic o_rw_oe, o_transfer_ctrl_low_oe, i_transfer_ctrl_top_n;
  logic o_transfer_ctrl_top_n, o_transfer_ctrl_top_oe;
  logic o_write_byte_enable_oe, o_serial_transmit_out;
  int fail_count = 0;
  int n_checks = 0;
  int cnt;

  // The reset pin is also the device's own reset input.
  assign i_arst_n = rst_b_n & i_reset_pin_n;

  ext_bus_pin_control #(.RST_DRIVE_CYCLES(DRV)) dut_u (.*);

  ext_bus_far_side far_u (.i_clk(i_core_clk), .i_en(m_en), .i_req(m_req),
    .i_dat(m_dat), .i_grant(o_bus_grant_out), .i_a(o_addr_pin),
    .i_a_oe(o_addr_oe), .i_d(o_data_pin), .i_d_oe(o_data_oe),
    .i_oe(o_oe_pin_n), .i_oe_oe(o_oe_pin_oe), .i_rw(o_rw_pin),
    .i_rw_oe(o_rw_oe), .i_tc3(o_transfer_ctrl_top_n),
    .i_tc3_oe(o_transfer_ctrl_top_oe), .i_wbe(o_write_byte_enable),
    .i_wbe_oe(o_write_byte_enable_oe), .i_rst(o_reset_pin_n),
    .i_rst_oe(o_reset_pin_oe), .o_a(i_addr_pin), .o_d(i_data_pin),
    .o_oe_n(i_oe_pin_n), .o_rw(i_rw_pin), .o_tc3_n(i_transfer_ctrl_top_n),
    .o_wbe(i_write_byte_enable), .o_rst_n(i_reset_pin_n));

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  function automatic logic [0:3] exp_wbe(ext_bus_pin_pkg::xfer_t x);
    logic [1:0] o;
    logic [0:3] e;
    o = x.addr[30:31];
    e = 4'hf;
    if (x.width == ext_bus_pin_pkg::BW_32) begin
      if (x.size == ext_bus_pin_pkg::SZ_WORD) e = 4'h0;
      else if (x.size == ext_bus_pin_pkg::SZ_HALF) e = o[1] ? 4'hc : 4'h3;
      else e = ~(4'h8 >> o);
      if (!x.wr_strobe) e = 4'hf;
    end else begin
      e[2:3] = o;
      if (x.wr_strobe && x.width == ext_bus_pin_pkg::BW_8) e[0:1] = 2'b01;
      else if (x.wr_strobe && x.size == ext_bus_pin_pkg::SZ_HALF)
        e[0:1] = 2'b00;
      else if (x.wr_strobe) e[0:1] = o[0] ? 2'b10 : 2'b01;
    end
    if (x.dram) e[0:1] = 2'b11;
    return e;
  endfunction : exp_wbe

  function automatic logic [6:29] exp_addr(ext_bus_pin_pkg::xfer_t x);
    logic [6:29] p;
    p = x.addr[6:29];
    for (int k = 0; k < 11 && x.int_mux; k++)
      p[19+k] = x.col_phase ? x.addr[21+k] : x.addr[12+k];
    for (int k = 0; k < 8 && x.int_mux; k++)
      p[11+k] = !x.col_phase ? x.addr[6+k] : k == 0 ? 1'b0 : x.addr[5+k];
    return p;
  endfunction : exp_addr

  task automatic drive_rand();
    ext_bus_pin_pkg::xfer_t x;
    logic [31:0] r;
    logic [95:0] w;
    r = rnd();
    w = {rnd(), rnd(), rnd()};
    x.addr = rnd();
    x.width = ext_bus_pin_pkg::bus_width_t'(r[1:0] % 2'd3);
    x.size = ext_bus_pin_pkg::xfer_size_t'(r[3:2] % 2'd3);
    if (x.width == ext_bus_pin_pkg::BW_8) x.size = ext_bus_pin_pkg::SZ_BYTE;
    if (x.width == ext_bus_pin_pkg::BW_16)
      x.size = ext_bus_pin_pkg::xfer_size_t'({1'b0, r[2]});
    if (x.size == ext_bus_pin_pkg::SZ_HALF) x.addr[31] = 1'b0;
    if (x.size == ext_bus_pin_pkg::SZ_WORD) x.addr[30:31] = 2'b00;
    x.dram = r[4] & r[5];
    x.wr_strobe = r[6] | r[7];
    x.int_mux = r[8];
    x.col_phase = r[8] & r[9];
    i_xfer = x;
    i_core = w[71:0];
    i_row_strobe_mode = r[13:10];
  endtask : drive_rand

  // Called one cycle after the inputs were set, before they change.
  task automatic chk_path(input logic g);
    if (!g) chk(o_write_byte_enable, exp_wbe(i_xfer), "wbe");
    if (!g) chk(o_addr_pin, exp_addr(i_xfer), "addr pins");
    chk(o_addr_mux_phase, i_xfer.col_phase, "mux phase");
    chk({o_cas_n, o_bus_state_out, o_serial_transmit_out, o_error},
        {i_core.cas_n, i_core.bus_state, i_core.xmit, i_core.error},
        "operable pins");
    chk({o_bus_request_out, o_ext_master_ack_n, o_dram_output_enable_n,
         o_dram_write_enable_n, o_chip_select_low_n, o_oe_pin_n, o_rw_pin,
         o_transfer_ctrl_top_n, o_transfer_ctrl_low_n,
         o_shared_select_row_strobe_n, o_data_pin},
        {i_core.bus_req, i_core.ext_master_ack_n, i_core.dram_oe_n, i_core.dram_we_n,
         i_core.cs_low_n, i_core.oe_n, i_core.rw, i_core.tc_top_n,
         g ? 3'h7 : i_core.tc_low_n,
         (i_core.ras_n & i_row_strobe_mode) |
         (i_core.cs_high_n & ~i_row_strobe_mode), i_core.data},
        "pin values");
    chk(o_dma_acknowledge_n, g ? 4'hf : i_core.dma_ack_n, "dma ack");
    chk({o_bus_grant_out, o_addr_oe, o_data_oe, o_chip_select_low_oe,
         o_oe_pin_oe, o_rw_oe, o_transfer_ctrl_top_oe,
         o_write_byte_enable_oe}, g ? 8'h80 :
        {3'b010 | {2'b00, i_core.data_drive}, 5'h1f}, "enables");
    if (g) chk({o_shared_select_row_strobe_oe, o_transfer_ctrl_low_n,
                o_transfer_ctrl_low_oe}, {i_row_strobe_mode, 4'hf},
               "grant selects");
  endtask : chk_path

  task automatic reset_chk(input int n);
    rst_b_n = 1'b0;
    repeat (n) @(negedge i_core_clk);
    chk({o_addr_oe, o_addr_mux_phase, o_bus_request_out, o_cas_n,
         o_chip_select_low_oe, o_shared_select_row_strobe_oe, o_data_oe,
         o_dma_acknowledge_n, o_ext_master_ack_n, o_dram_output_enable_n,
         o_dram_write_enable_n, o_error, o_bus_grant_out, o_oe_pin_oe,
         o_reset_pin_oe, o_rw_oe, o_transfer_ctrl_low_oe,
         o_transfer_ctrl_top_oe, o_bus_state_out, o_write_byte_enable_oe,
         o_serial_transmit_out}, {3'b000, 4'hf, 1'b0, 4'h0, 1'b0, 4'hf,
         3'b111, 7'h00, 7'h00, 1'b0, 1'b1}, "reset state");
    rst_b_n = 1'b1;
    i_por_n = 1'b1;
  endtask : reset_chk

  initial begin
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    $display("mismatch at %0t: run did not finish", $time);
    print_verdict();
  end

  initial begin
    {rst_b_n, i_por_n, i_hold_grant, i_sys_reset_req, m_en} = 5'h00;
    i_core = '0;
    i_xfer = '0;
    i_row_strobe_mode = 4'h0;
    m_req = '0;
    m_dat = 32'h0;
    reset_chk(20);
    for (int n = 0; n < 300; n++) begin
      drive_rand();
      @(negedge i_core_clk);
      chk_path(1'b0);
    end
    for (int n = 0; n < 4; n++) begin
      m_dat = rnd();
      cnt = rnd();
      m_req = cnt[30:0];
      m_en = 1'b1;
      i_hold_grant = 1'b1;
      for (int k = 1; k <= 8; k++) begin
        drive_rand();
        @(negedge i_core_clk);
        chk_path(1'b1);
        if (k > 2) chk({o_ext_req, o_ext_data}, {m_req, m_dat}, "ext req");
      end
      // Reset must win over a grant that is still requested.
      if (n == 3) reset_chk(4);
      i_hold_grant = 1'b0;
      drive_rand();
      @(negedge i_core_clk);
      chk_path(1'b0);
    end
    i_sys_reset_req = 1'b1;
    @(negedge i_core_clk);
    i_sys_reset_req = 1'b0;
    cnt = 0;
    while (o_reset_pin_oe === 1'b1 && cnt < 200) begin
      chk({o_reset_pin_n, o_addr_oe, o_sys_reset_busy}, 3'b001,
          "reset drive");
      cnt++;
      @(negedge i_core_clk);
    end
    chk(cnt >= DRV + 2 && cnt <= DRV + 4, 1'b1, "reset length");
    repeat (8) @(negedge i_core_clk);
    chk(o_sys_reset_busy, 1'b0, "reset busy");
    for (int n = 0; n < 50; n++) begin
      drive_rand();
      @(negedge i_core_clk);
      chk_path(1'b0);
    end
    print_verdict();
  end
endmodule : ext_bus_pin_control_test
